// ===== srcp_cluster_slice.sv
// Cluster register slice: input buffers, storage, semaphores and return path.
`timescale 1ns/1ps

module srcp_cluster_slice (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // AHB-Lite register port.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // References from the crossbar slices.
  input wire logic xb_ctl_valid,
  input wire logic [3:0] xb_cmd,
  input wire logic [5:0] xb_rptr,
  input wire logic xb_sel,
  input wire logic [4:0] xb_scpu,
  input wire logic xb_sel_bad,
  input wire logic [31:0] xb_data,
  output logic xb_resume,
  // Deadlock event from the test-and-set logic.
  input wire logic dl_event,
  input wire logic [4:0] dl_scpu,
  // Remote response competing for the return path.
  input wire logic rem_req,
  output logic rem_ack,
  // Holding-buffer arbitration.
  input wire logic [9:0] hold_req,
  output logic [9:0] hold_grant,
  // Return toward the return-data and CPU-side slices.
  output logic ret_valid,
  output logic ret_first,
  output logic [1:0] ret_src,
  output logic [3:0] ret_code,
  output logic [5:0] ret_cmd,
  output logic [3:0] ret_ptr,
  output logic ret_pair,
  output logic [1:0] ret_path,
  output logic ret_perr,
  output logic [31:0] ret_data
);

  typedef struct packed {
    srcp_pkg::srcp_cap_t cap_ph;
    srcp_pkg::srcp_entry_t cap;
    logic a_full;
    logic b_full;
    srcp_pkg::srcp_entry_t a;
    srcp_pkg::srcp_entry_t b;
    logic resume;
    logic [1:0][63:0] sem;
    logic [1:0][31:0] attach;
    logic loc_pend;
    logic loc_perr;
    logic [3:0] loc_code;
    logic [4:0] loc_scpu;
    logic [63:0] loc_data;
    logic fst_pend;
    logic [3:0] fst_code;
    logic [4:0] fst_scpu;
    logic dl_pend;
    logic [4:0] dl_scpu;
    logic out_busy;
    logic [63:0] out_word;
    logic [1:0] rr_head;
    logic rem_ack;
    logic ret_valid;
    logic ret_first;
    logic [1:0] ret_src;
    logic [3:0] ret_code;
    logic [5:0] ret_cmd;
    logic [3:0] ret_ptr;
    logic ret_pair;
    logic [1:0] ret_path;
    logic ret_perr;
    logic [31:0] ret_data;
    logic hold_turn;
    logic [2:0] head_a;
    logic [2:0] head_b;
    logic [9:0] hold_grant;
    logic [1:0] ctrl;
    logic [15:0] perr_cnt;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
  } srcp_state_t;

  srcp_state_t st;
  srcp_state_t next_st;

  // Storage-side signals, combinational.
  logic [5:0] addr6;
  logic [1:0] steer;
  logic [3:0] code;
  logic [3:0][17:0] rd_row;
  logic [63:0] rd_word;
  logic rd_perr;
  logic mem_we;
  logic [63:0] mem_wword;
  logic [3:0][17:0] mem_wrow;

  // Command translation; codes the slice makes itself never come in.
  function automatic logic [3:0] srcp_xlate(input logic [3:0] cmd);
    if (cmd == srcp_pkg::CODE_NONE || cmd == srcp_pkg::CODE_DEADLK) begin
      return srcp_pkg::CODE_NONE;
    end
    return cmd;
  endfunction : srcp_xlate

  // Rotating pick among five requests, starting at head.
  function automatic logic [3:0] srcp_pick5(input logic [4:0] req, input logic [2:0] head);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h0;
    idx = head;
    for (int i = 0; i < srcp_pkg::HOLD_PER_GRP; i++) begin
      if (!res[3] && req[idx]) begin
        res = {1'b1, idx};
      end
      idx = (idx == srcp_pkg::HOLD_LAST) ? 3'h0 : idx + 3'h1;
    end
    return res;
  endfunction : srcp_pick5

  // Address from code bit 2, cluster and register number.
  // address forming
  assign code = srcp_xlate(st.a.cmd);
  assign addr6 = {code[2], st.a.sel, st.a.rptr[3:0]};
  assign steer = st.a.rptr[5:4];

  // Four arrays; the upper pointer bits rotate which array holds which block.
  // storage arrays
  for (genvar i = 0; i < 4; i++) begin : g_arr
    logic [17:0] mem [0:63];
    always_ff @(posedge sys_clk) begin
      if (mem_we) begin
        mem[addr6] <= mem_wrow[i];
      end
    end
    assign rd_row[i] = mem[addr6];
  end

  // Block steering and parity; the inject bit lets software prove the checker.
  // parity check
  always_comb begin
    rd_word = 64'h0;
    rd_perr = 1'b0;
    mem_wrow = '0;
    for (int k = 0; k < 4; k++) begin
      rd_word[k*16 +: 16] = rd_row[2'(k) + steer][15:0];
      mem_wrow[2'(k) + steer] = {1'b0,
        (^mem_wword[k*16 +: 16]) ^ st.ctrl[srcp_pkg::CTRL_PINV_BIT], mem_wword[k*16 +: 16]};
      rd_perr = rd_perr | (rd_row[k][16] != ^rd_row[k][15:0]);
    end
  end

  // Whole next-state function.
  always_comb begin
    logic a_pop;
    logic exec;
    logic push;
    logic resp;
    logic [63:0] rdata;
    logic [3:0] pick;
    logic [2:0] reqs;
    logic [1:0] idx;
    logic [1:0] win;
    logic won;
    a_pop = 1'b0;
    exec = 1'b0;
    push = 1'b0;
    resp = 1'b0;
    rdata = 64'h0;
    pick = 4'h0;
    reqs = 3'h0;
    idx = 2'h0;
    win = 2'h0;
    won = 1'b0;
    next_st = st;
    next_st.resume = 1'b0;
    next_st.rem_ack = 1'b0;
    next_st.hold_grant = 10'h0;
    mem_we = 1'b0;
    mem_wword = st.a.data;

    // Control arrives one phase ahead of the two data phases.
    // capture sequence
    unique case (st.cap_ph)
      srcp_pkg::CAP_CTL: begin
        if (xb_ctl_valid) begin
          next_st.cap.cmd = xb_cmd;
          next_st.cap.rptr = xb_rptr;
          next_st.cap.sel = xb_sel;
          next_st.cap.scpu = xb_scpu;
          next_st.cap.bad = xb_sel_bad;
          next_st.cap_ph = srcp_pkg::CAP_LO;
        end
      end
      srcp_pkg::CAP_LO: begin
        next_st.cap.data[31:0] = xb_data;
        next_st.cap_ph = srcp_pkg::CAP_HI;
      end
      srcp_pkg::CAP_HI: begin
        next_st.cap.data[63:32] = xb_data;
        next_st.cap_ph = srcp_pkg::CAP_CTL;
        push = 1'b1;
      end
    endcase

    // A deadlock report takes the local slot ahead of buffer A.
    // deadlock report
    if (st.dl_pend && !st.loc_pend) begin
      next_st.loc_pend = 1'b1;
      next_st.loc_perr = 1'b0;
      next_st.loc_code = srcp_pkg::CODE_DEADLK;
      next_st.loc_scpu = st.dl_scpu;
      next_st.loc_data = 64'h0;
      next_st.dl_pend = 1'b0;
    end else if (st.a_full && st.ctrl[srcp_pkg::CTRL_EN_BIT] && !st.loc_pend
                 && !st.fst_pend) begin
      exec = 1'b1;
    end
    if (dl_event) begin
      next_st.dl_pend = 1'b1;
      next_st.dl_scpu = dl_scpu;
    end

    // Illegal select answers early; everything else executes.
    // fast response
    if (exec && st.a.bad) begin
      a_pop = 1'b1;
      next_st.fst_pend = 1'b1;
      next_st.fst_code = code;
      next_st.fst_scpu = st.a.scpu;
    end else if (exec) begin
      a_pop = 1'b1;
      unique case (code)
        srcp_pkg::CODE_RDINC: begin
          resp = 1'b1;
          rdata = rd_word;
          mem_we = 1'b1;
          mem_wword = rd_word + 64'h1;
        end
        srcp_pkg::CODE_RDSB, srcp_pkg::CODE_RDST: begin
          resp = 1'b1;
          rdata = rd_word;
        end
        srcp_pkg::CODE_WRSB, srcp_pkg::CODE_WRST: begin
          mem_we = 1'b1;
        end
        srcp_pkg::CODE_JMPSET: begin
          resp = 1'b1;
          rdata = {63'h0, st.sem[st.a.sel][st.a.rptr]};
          next_st.sem[st.a.sel][st.a.rptr] = 1'b1;
        end
        srcp_pkg::CODE_RDSEM: begin
          resp = 1'b1;
          rdata = st.sem[st.a.sel];
        end
        srcp_pkg::CODE_WRSEM: begin
          next_st.sem[st.a.sel] = st.a.data;
        end
        srcp_pkg::CODE_TAS: begin
          // A set semaphore leaves the request in A to be retried.
          if (st.sem[st.a.sel][st.a.rptr]) begin
            a_pop = 1'b0;
          end else begin
            resp = 1'b1;
            rdata = 64'h1;
            next_st.sem[st.a.sel][st.a.rptr] = 1'b1;
          end
        end
        srcp_pkg::CODE_CLRSEM: begin
          next_st.sem[st.a.sel][st.a.rptr] = 1'b0;
        end
        srcp_pkg::CODE_SETSEM: begin
          next_st.sem[st.a.sel][st.a.rptr] = 1'b1;
        end
        srcp_pkg::CODE_ATTACH: begin
          next_st.attach[st.a.sel][st.a.scpu] = 1'b1;
        end
        srcp_pkg::CODE_DETACH: begin
          next_st.attach[st.a.sel] = 32'h0;
        end
        default: begin
          // Flush and untranslatable codes only retire the entry.
        end
      endcase
      if (resp) begin
        next_st.loc_pend = 1'b1;
        next_st.loc_perr = rd_perr && !code[3];
        next_st.loc_code = (rd_perr && !code[3]) ? srcp_pkg::CODE_PERR : code;
        next_st.loc_scpu = st.a.scpu;
        next_st.loc_data = rdata;
      end
    end
    if (exec && resp && rd_perr && !code[3]) begin
      next_st.perr_cnt = st.perr_cnt + 16'h1;
    end

    // B moves up as A empties, then new input fills the first free buffer.
    // buffer advance
    next_st.a_full = st.a_full && !a_pop;
    if (!next_st.a_full && st.b_full) begin
      next_st.a = st.b;
      next_st.a_full = 1'b1;
      next_st.b_full = 1'b0;
      next_st.resume = 1'b1;
    end
    if (push && !next_st.a_full) begin
      next_st.a = next_st.cap;
      next_st.a_full = 1'b1;
    end else if (push) begin
      next_st.b = next_st.cap;
      next_st.b_full = 1'b1;
    end

    // Return slot: remote, fast and local compete, winner goes last.
    // source rotation
    reqs = {st.loc_pend, st.fst_pend, rem_req};
    idx = st.rr_head;
    for (int i = 0; i < 3; i++) begin
      if (!won && reqs[idx]) begin
        won = 1'b1;
        win = idx;
      end
      idx = (idx == srcp_pkg::SRC_LOCAL) ? srcp_pkg::SRC_REMOTE : idx + 2'h1;
    end
    if (st.out_busy && st.ret_first) begin
      next_st.ret_first = 1'b0;
      next_st.ret_data = st.out_word[63:32];
    end else if (st.out_busy) begin
      next_st.out_busy = 1'b0;
      next_st.ret_valid = 1'b0;
    end else if (won) begin
      next_st.out_busy = 1'b1;
      next_st.ret_first = 1'b1;
      next_st.ret_src = win;
      next_st.rr_head = (win == srcp_pkg::SRC_LOCAL) ? srcp_pkg::SRC_REMOTE : win + 2'h1;
      next_st.ret_valid = (win != srcp_pkg::SRC_REMOTE);
      next_st.rem_ack = (win == srcp_pkg::SRC_REMOTE);
      next_st.out_word = (win == srcp_pkg::SRC_LOCAL) ? st.loc_data : 64'h0;
      next_st.ret_data = next_st.out_word[31:0];
      next_st.ret_code = (win == srcp_pkg::SRC_LOCAL) ? st.loc_code : st.fst_code;
      next_st.ret_perr = (win == srcp_pkg::SRC_LOCAL) && st.loc_perr;
      next_st.ret_cmd = {!next_st.ret_code[3], next_st.ret_code[3], next_st.ret_code};
      if (win != srcp_pkg::SRC_REMOTE) begin
        next_st.ret_pair = (win == srcp_pkg::SRC_LOCAL) ? st.loc_scpu[2] : st.fst_scpu[2];
        next_st.ret_ptr = (win == srcp_pkg::SRC_LOCAL)
          ? {st.loc_scpu[4:3], st.loc_scpu[1:0]} : {st.fst_scpu[4:3], st.fst_scpu[1:0]};
        next_st.ret_path = (win == srcp_pkg::SRC_LOCAL)
          ? {st.loc_scpu[4], st.loc_scpu[1]} : {st.fst_scpu[4], st.fst_scpu[1]};
      end
      if (win == srcp_pkg::SRC_LOCAL) begin
        next_st.loc_pend = 1'b0;
      end
      if (win == srcp_pkg::SRC_FAST) begin
        next_st.fst_pend = 1'b0;
      end
    end

    // Holding buffers: preferred group first, winner rotates to last.
    // group arbitration
    if (!st.hold_turn) begin
      pick = srcp_pick5(hold_req[4:0], st.head_a);
    end else begin
      pick = srcp_pick5(hold_req[9:5], st.head_b);
    end
    if (!pick[3]) begin
      pick = st.hold_turn ? srcp_pick5(hold_req[4:0], st.head_a)
                          : srcp_pick5(hold_req[9:5], st.head_b);
      next_st.hold_turn = !st.hold_turn;
    end
    if (pick[3]) begin
      next_st.hold_turn = !next_st.hold_turn;
      if (next_st.hold_turn) begin
        next_st.hold_grant[pick[2:0]] = 1'b1;
        next_st.head_a = (pick[2:0] == srcp_pkg::HOLD_LAST) ? 3'h0 : pick[2:0] + 3'h1;
      end else begin
        next_st.hold_grant[pick[2:0] + 4'h5] = 1'b1;
        next_st.head_b = (pick[2:0] == srcp_pkg::HOLD_LAST) ? 3'h0 : pick[2:0] + 3'h1;
      end
    end else begin
      next_st.hold_turn = st.hold_turn;
    end

    // Bus: read data is prepared in the address phase, writes land a cycle later.
    if (st.wr_pend) begin
      next_st.wr_pend = 1'b0;
      if (st.wr_addr == srcp_pkg::ADDR_CTRL) begin
        next_st.ctrl = hwdata[1:0];
      end else if (st.wr_addr == srcp_pkg::ADDR_PERR) begin
        // A parity error in the same cycle still counts.
        next_st.perr_cnt = (exec && resp && rd_perr && !code[3]) ? 16'h1 : 16'h0;
      end
    end
    if (hsel && htrans[1] && hready) begin
      next_st.wr_pend = hwrite && (hsize == 3'h2);
      next_st.wr_addr = haddr[7:0];
      unique case (haddr[7:0])
        srcp_pkg::ADDR_CTRL: next_st.hrdata = {30'h0, st.ctrl};
        srcp_pkg::ADDR_STAT: next_st.hrdata = {26'h0, st.out_busy, st.dl_pend,
          st.fst_pend, st.loc_pend, st.b_full, st.a_full};
        srcp_pkg::ADDR_PERR: next_st.hrdata = {16'h0, st.perr_cnt};
        default: next_st.hrdata = 32'h0;
      endcase
    end
  end

  // State register; reset empties buffers and restores arbiter orders.
  // reset state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= srcp_pkg::CTRL_RESET;
      st.rr_head <= srcp_pkg::SRC_REMOTE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops, except hreadyout and hresp, tied high and low.
  assign hrdata = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign xb_resume = st.resume;
  assign rem_ack = st.rem_ack;
  assign hold_grant = st.hold_grant;
  assign ret_valid = st.ret_valid;
  assign ret_first = st.ret_first;
  assign ret_src = st.ret_src;
  assign ret_code = st.ret_code;
  assign ret_cmd = st.ret_cmd;
  assign ret_ptr = st.ret_ptr;
  assign ret_pair = st.ret_pair;
  assign ret_path = st.ret_path;
  assign ret_perr = st.ret_perr;
  assign ret_data = st.ret_data;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  buf_order_a: assert property (st.b_full |-> st.a_full)
    else $error("buffer B full while A empty");
  resume_fill_a: assert property (xb_resume |-> st.a_full && $past(st.b_full))
    else $error("resume without B advancing");
  fast_cause_a: assert property ($rose(st.fst_pend) |-> $past(st.a.bad && st.a_full))
    else $error("fast response without illegal select");
  cmd_restore_a: assert property (
    ret_valid && ret_first |-> ret_cmd[3:0] == ret_code
    && ret_cmd[5:4] == (ret_code[3] ? 2'h1 : 2'h2))
    else $error("restored command prefix wrong");
  two_phase_a: assert property (
    ret_valid && ret_first |=> ret_valid && !ret_first ##1 !ret_valid)
    else $error("return word not two phases");
  rr_rotate_a: assert property (rem_ack |-> st.rr_head == srcp_pkg::SRC_FAST)
    else $error("remote winner not moved to last");
  hold_grant_a: assert property (
    $onehot0(hold_grant) && ((hold_grant & ~$past(hold_req)) == 10'h0))
    else $error("hold grant without request");
  perr_code_a: assert property (
    st.loc_pend && st.loc_perr |-> st.loc_code == srcp_pkg::CODE_PERR)
    else $error("parity error without code 03");
  sem_set_a: assert property (
    st.a_full && !st.a.bad && code == srcp_pkg::CODE_SETSEM && !st.loc_pend && !st.fst_pend
    && !st.dl_pend && st.ctrl[0] |=> st.sem[$past(st.a.sel)][$past(st.a.rptr)])
    else $error("set semaphore not set");
  attach_set_a: assert property (
    st.a_full && !st.a.bad && code == srcp_pkg::CODE_ATTACH && !st.loc_pend && !st.fst_pend
    && !st.dl_pend && st.ctrl[0] |=> st.attach[$past(st.a.sel)][$past(st.a.scpu)])
    else $error("attach bit not set");
  detach_all_a: assert property (
    st.a_full && !st.a.bad && code == srcp_pkg::CODE_DETACH && !st.loc_pend && !st.fst_pend
    && !st.dl_pend && st.ctrl[0] |=> st.attach[$past(st.a.sel)] == 32'h0)
    else $error("detach left attach bits");
  reset_empty_a: assert property (
    $past(rst) |-> !st.a_full && !st.b_full && st.rr_head == srcp_pkg::SRC_REMOTE)
    else $error("state not cleared by reset");

endmodule : srcp_cluster_slice

// ===== srcp_pkg.sv
// Constants, codes and types shared by the cluster register slice.
package srcp_pkg;

  // Register offsets on the AHB-Lite bus, byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_PERR = 8'h08;

  // Control register fields and value after reset.
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PINV_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // Internal four-bit control codes.
  localparam logic [3:0] CODE_NONE = 4'h0;
  localparam logic [3:0] CODE_RDINC = 4'h1;
  localparam logic [3:0] CODE_RDSB = 4'h2;
  localparam logic [3:0] CODE_WRSB = 4'h3;
  localparam logic [3:0] CODE_PERR = 4'h3;
  localparam logic [3:0] CODE_RDST = 4'h4;
  localparam logic [3:0] CODE_WRST = 4'h5;
  localparam logic [3:0] CODE_DEADLK = 4'h6;
  localparam logic [3:0] CODE_ATTACH = 4'h7;
  localparam logic [3:0] CODE_JMPSET = 4'h8;
  localparam logic [3:0] CODE_RDSEM = 4'h9;
  localparam logic [3:0] CODE_DETACH = 4'ha;
  localparam logic [3:0] CODE_WRSEM = 4'hb;
  localparam logic [3:0] CODE_TAS = 4'hc;
  localparam logic [3:0] CODE_FLUSH = 4'hd;
  localparam logic [3:0] CODE_CLRSEM = 4'he;
  localparam logic [3:0] CODE_SETSEM = 4'hf;

  // Return-slot sources, also the initial round-robin order.
  localparam logic [1:0] SRC_REMOTE = 2'h0;
  localparam logic [1:0] SRC_FAST = 2'h1;
  localparam logic [1:0] SRC_LOCAL = 2'h2;
  localparam logic [1:0] SRC_COUNT = 2'h3;

  // Holding-buffer arbiter geometry.
  localparam int HOLD_PER_GRP = 5;
  localparam logic [2:0] HOLD_LAST = 3'h4;

  // Input capture sequence: control phase, then two data phases.
  typedef enum logic [1:0] {CAP_CTL, CAP_LO, CAP_HI} srcp_cap_t;

  // One buffered reference.
  typedef struct packed {
    logic [3:0] cmd;
    logic [5:0] rptr;
    logic sel;
    logic [4:0] scpu;
    logic bad;
    logic [63:0] data;
  } srcp_entry_t;

endpackage : srcp_pkg

// ===== srcp_xbar_model.sv
// Crossbar-side sender model that feeds references into the cluster slice.
`timescale 1ns/1ps
module srcp_xbar_model (
  // Clock.
  input wire logic sys_clk,
  // Reference toward the cluster slice.
  output logic xb_ctl_valid,
  output logic [3:0] xb_cmd,
  output logic [5:0] xb_rptr,
  output logic xb_sel,
  output logic [4:0] xb_scpu,
  output logic xb_sel_bad,
  output logic [31:0] xb_data
);
  // Idle lines start low so the slice sees known values from time zero.
  initial begin
    xb_ctl_valid = 1'h0;
    xb_cmd = 4'h0;
    xb_rptr = 6'h00;
    xb_sel = 1'h0;
    xb_scpu = 5'h00;
    xb_sel_bad = 1'h0;
    xb_data = 32'h0;
  end

  // control one phase ahead.
  // Two data words follow; the released data line shows the inverse of its last value.
  task automatic send(input logic [3:0] c, input logic [5:0] p, input logic s,
                      input logic [4:0] u, input logic b, input logic [63:0] d);
    @(posedge sys_clk);
    xb_ctl_valid <= 1'h1;
    xb_cmd <= c;
    xb_rptr <= p;
    xb_sel <= s;
    xb_scpu <= u;
    xb_sel_bad <= b;
    @(posedge sys_clk);
    xb_ctl_valid <= 1'h0;
    xb_data <= d[31:0];
    @(posedge sys_clk);
    xb_data <= d[63:32];
    @(posedge sys_clk);
    xb_data <= ~d[63:32];
  endtask : send
endmodule : srcp_xbar_model

// ===== tb_top.sv
// Self-checking testbench for the cluster register slice.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, xb_ctl_valid, xb_sel, xb_sel_bad, xb_resume;
  logic [3:0] xb_cmd, ret_code, ret_ptr;
  logic [5:0] xb_rptr, ret_cmd;
  logic [4:0] xb_scpu;
  logic [31:0] xb_data, ret_data, rd;
  logic dl_event = 1'h0;
  logic rem_req = 1'h0;
  logic rem_ack, ret_valid, ret_first, ret_pair, ret_perr, r_perr, r_pair, seen;
  logic [9:0] hold_req = 10'h0;
  logic [9:0] hold_grant, g0, g1, g2;
  logic [1:0] ret_src, ret_path, r_src, r_path;
  logic [3:0] r_code, r_ptr;
  logic [5:0] r_cmd;
  logic [63:0] r_word;
  int mismatches = 0;
  int n_checks = 0;
  localparam logic [4:0] SCPU = 5'h16;
  localparam logic [63:0] DW = 64'h0123_4567_89ab_cd10;
  localparam logic [63:0] EW = 64'hfedc_ba98_7654_3200;

  // Clock of 100 ns period.
  always #50 sys_clk = ~sys_clk;

  // Device under test and its crossbar partner.
  srcp_cluster_slice srcp_cluster_slice_inst (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .xb_ctl_valid(xb_ctl_valid), .xb_cmd(xb_cmd), .xb_rptr(xb_rptr), .xb_sel(xb_sel),
    .xb_scpu(xb_scpu), .xb_sel_bad(xb_sel_bad), .xb_data(xb_data), .xb_resume(xb_resume),
    .dl_event(dl_event), .dl_scpu(SCPU), .rem_req(rem_req), .rem_ack(rem_ack),
    .hold_req(hold_req), .hold_grant(hold_grant), .ret_valid(ret_valid),
    .ret_first(ret_first), .ret_src(ret_src), .ret_code(ret_code), .ret_cmd(ret_cmd),
    .ret_ptr(ret_ptr), .ret_pair(ret_pair), .ret_path(ret_path), .ret_perr(ret_perr),
    .ret_data(ret_data));
  srcp_xbar_model srcp_xbar_model_inst (.sys_clk(sys_clk), .xb_ctl_valid(xb_ctl_valid),
    .xb_cmd(xb_cmd), .xb_rptr(xb_rptr), .xb_sel(xb_sel), .xb_scpu(xb_scpu),
    .xb_sel_bad(xb_sel_bad), .xb_data(xb_data));

  // Compares one value and counts it.
  task automatic check(input string nm, input logic [63:0] seen_v, input logic [63:0] exp);
    n_checks++;
    if (seen_v !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen_v);
    end
  endtask : check

  // Single AHB-Lite transfer; the address phase is held until hready is seen high.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'h1) @(posedge sys_clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'h1) @(posedge sys_clk);
    rd = hrdata;
  endtask : ahb

  // Waits a bounded time for a two-phase response and captures it.
  task automatic wait_ret();
    seen = 1'h0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(posedge sys_clk);
      seen = (ret_valid === 1'h1 && ret_first === 1'h1);
    end
    check("ret_seen", seen, 1);
    {r_src, r_code, r_cmd, r_ptr, r_pair, r_path, r_perr} =
      {ret_src, ret_code, ret_cmd, ret_ptr, ret_pair, ret_path, ret_perr};
    r_word[31:0] = ret_data;
    @(posedge sys_clk);
    r_word[63:32] = ret_data;
    check("ret_first_2nd", ret_first, 0);
  endtask : wait_ret

  // Sends a reference; reads wait for their response, other commands let the path settle.
  task automatic op(input logic [3:0] c, input logic [5:0] p, input logic s, input logic b,
                    input logic [63:0] d, input logic rdq);
    srcp_xbar_model_inst.send(c, p, s, SCPU, b, d);
    if (rdq) wait_ret();
    else repeat (10) @(posedge sys_clk);
  endtask : op

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  // Watchdog sized well above the expected few hundred cycles.
  initial begin
    #(5000 * 100);
    mismatches++;
    results();
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'h0;
    check("ret_valid_rst", ret_valid, 0);
    ahb(1'h0, srcp_pkg::ADDR_CTRL, 32'h0);
    check("ctrl_rst", rd, srcp_pkg::CTRL_RESET);
    ahb(1'h0, 8'h0c, 32'h0);
    check("unmapped", rd, 0);
    check("hresp", hresp, 0);
    op(srcp_pkg::CODE_WRSB, 6'h25, 1'h1, 1'h0, DW, 1'h0);
    op(srcp_pkg::CODE_RDSB, 6'h25, 1'h1, 1'h0, 64'h0, 1'h1);
    check("b_data", r_word, DW);
    check("b_cmd", r_cmd, 6'h22);
    check("b_route", {r_src, r_ptr, r_pair, r_path},
          {srcp_pkg::SRC_LOCAL, 4'ha, 1'h1, 2'h3});
    op(srcp_pkg::CODE_RDINC, 6'h25, 1'h1, 1'h0, 64'h0, 1'h1);
    check("inc_old", r_word, DW);
    op(srcp_pkg::CODE_WRST, 6'h25, 1'h1, 1'h0, EW, 1'h0);
    op(srcp_pkg::CODE_RDST, 6'h25, 1'h1, 1'h0, 64'h0, 1'h1);
    check("scalar_data", r_word, EW);
    op(srcp_pkg::CODE_RDSB, 6'h25, 1'h1, 1'h0, 64'h0, 1'h1);
    check("inc_new", r_word, DW + 64'h1);
    ahb(1'h1, srcp_pkg::ADDR_CTRL, 32'h3);
    op(srcp_pkg::CODE_WRSB, 6'h11, 1'h0, 1'h0, EW, 1'h0);
    ahb(1'h1, srcp_pkg::ADDR_CTRL, 32'h1);
    op(srcp_pkg::CODE_RDSB, 6'h11, 1'h0, 1'h0, 64'h0, 1'h1);
    check("perr_word", r_word, EW);
    check("perr_code", {r_perr, r_code, r_cmd}, {1'h1, srcp_pkg::CODE_PERR, 6'h23});
    ahb(1'h0, srcp_pkg::ADDR_PERR, 32'h0);
    check("perr_cnt", rd, 1);
    op(srcp_pkg::CODE_WRSEM, 6'h00, 1'h0, 1'h0, 64'h0, 1'h0);
    op(srcp_pkg::CODE_SETSEM, 6'h07, 1'h0, 1'h0, 64'h0, 1'h0);
    op(srcp_pkg::CODE_TAS, 6'h03, 1'h0, 1'h0, 64'h0, 1'h1);
    check("tas_code", r_code, srcp_pkg::CODE_TAS);
    check("tas_word", r_word, 64'h1);
    op(srcp_pkg::CODE_RDSEM, 6'h00, 1'h0, 1'h0, 64'h0, 1'h1);
    check("sem_cmd", r_cmd, 6'h19);
    check("sem_all", r_word, 64'h88);
    op(srcp_pkg::CODE_CLRSEM, 6'h07, 1'h0, 1'h0, 64'h0, 1'h0);
    op(srcp_pkg::CODE_RDSEM, 6'h00, 1'h0, 1'h0, 64'h0, 1'h1);
    check("sem_clr", r_word, 64'h8);
    op(srcp_pkg::CODE_ATTACH, 6'h00, 1'h1, 1'h0, 64'h0, 1'h0);
    op(srcp_pkg::CODE_DETACH, 6'h00, 1'h1, 1'h0, 64'h0, 1'h0);
    op(srcp_pkg::CODE_RDSB, 6'h25, 1'h1, 1'h1, 64'h0, 1'h1);
    check("fast_src", r_src, srcp_pkg::SRC_FAST);
    dl_event <= 1'h1;
    @(posedge sys_clk);
    dl_event <= 1'h0;
    wait_ret();
    check("deadlock", {r_code, r_cmd}, {srcp_pkg::CODE_DEADLK, 6'h26});
    rem_req <= 1'h1;
    seen = 1'h0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(posedge sys_clk);
      seen = (rem_ack === 1'h1);
    end
    rem_req <= 1'h0;
    check("rem_ack", seen, 1);
    hold_req <= 10'h3ff;
    g0 = 10'h0;
    for (int i = 0; i < 40 && g0 === 10'h0; i++) @(posedge sys_clk) g0 = hold_grant;
    g1 = 10'h0;
    for (int i = 0; i < 40 && g1 === 10'h0; i++) @(posedge sys_clk) g1 = hold_grant;
    g2 = 10'h0;
    for (int i = 0; i < 40 && g2 === 10'h0; i++) @(posedge sys_clk) g2 = hold_grant;
    hold_req <= 10'h0;
    check("hold_grants", {g0, g1, g2}, {10'h001, 10'h020, 10'h002});
    // Execution held off: two references fill A then B, enabling lets B advance.
    ahb(1'h1, srcp_pkg::ADDR_CTRL, 32'h0);
    op(srcp_pkg::CODE_FLUSH, 6'h00, 1'h0, 1'h0, 64'h0, 1'h0);
    op(srcp_pkg::CODE_FLUSH, 6'h00, 1'h0, 1'h0, 64'h0, 1'h0);
    ahb(1'h0, srcp_pkg::ADDR_STAT, 32'h0);
    check("stat_ab", rd, 3);
    ahb(1'h1, srcp_pkg::ADDR_CTRL, 32'h1);
    seen = 1'h0;
    for (int i = 0; i < 10 && !seen; i++) @(posedge sys_clk) seen = (xb_resume === 1'h1);
    check("resume", seen, 1);
    // A held entry and a disabled slice must be cleared by a mid-run reset.
    ahb(1'h1, srcp_pkg::ADDR_CTRL, 32'h0);
    op(srcp_pkg::CODE_FLUSH, 6'h00, 1'h0, 1'h0, 64'h0, 1'h0);
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    ahb(1'h0, srcp_pkg::ADDR_STAT, 32'h0);
    check("stat_rst", rd, 0);
    ahb(1'h0, srcp_pkg::ADDR_CTRL, 32'h0);
    check("ctrl_rst2", rd, srcp_pkg::CTRL_RESET);
    results();
  end
endmodule : tb_top
